// *** src/fpsc_defs.svh ***
// constants for the power-down / otp / security command block
// ============================================================
// Notes on behaviour
// - power-down runs only if select rises after eight bits
// - opcode takes 8 clocks single, 2 clocks quad
// - deep power-down entered after the entry delay
// - in power-down only release command is obeyed
// - release, power cycle or reset leave power-down
// - enter-otp command redirects reads and programs to otp
// - locked otp region refuses all programs
// - exit-otp command restores main array access
// - write-security needs write enable, sets lock bit1
// - lock flag of one freezes flag and region
// - write-security rejected unless select rises on boundary
// - read-security served at any time except in power-down, repeatedly
// - read-security: opcode in, register out, select ends
// - erase-fail bit6 set on failure, cleared on success
// - program-fail bit5 set on failure, cleared on success
// - erase-suspended bit3 set on suspend, cleared on resume
// - program-suspended bit2 set on suspend, cleared on resume
// - bit0 reports factory lock of otp region
// - protection-mode select bit7 defaults 0, sticks at 1
// - host issues write enable before nonvolatile changes
`ifndef FPSC_DEFS_SVH
`define FPSC_DEFS_SVH
// ============================================================
// opcodes
`define FPSC_OP_WRITE_ENABLE_CMD     8'h06
`define FPSC_OP_DP       8'hb9
`define FPSC_OP_RDP      8'hab
`define FPSC_OP_ENTER_OTP_MODE_CMD     8'hb1
`define FPSC_OP_EXIT_OTP_MODE_CMD     8'hc1
`define FPSC_OP_WRITE_SECURITY_CMD   8'h2f
`define FPSC_OP_READ_SECURITY_CMD   8'h2b
// ============================================================
// security register bit positions
`define FPSC_B_FACT      0
`define FPSC_B_LOCK      1
`define FPSC_B_PSUS      2
`define FPSC_B_ESUS      3
`define FPSC_B_PFAIL     5
`define FPSC_B_EFAIL     6
`define FPSC_B_PMSEL     7
// ============================================================
// timing: entry delay in ns, cycles at 20 ns rounded up
`define FPSC_CLK_NS      20
`define FPSC_TDP_NS      10000
`define FPSC_TDP_CYC     ((`FPSC_TDP_NS + `FPSC_CLK_NS - 1) / `FPSC_CLK_NS)
// host serial clock divider (half period in hclk cycles)
`define FPSC_SCK_HALF    4
// ============================================================
// controller register offsets (byte addresses)
`define FPSC_A_CMD       8'h00
`define FPSC_A_STAT      8'h04
`define FPSC_A_RDATA     8'h08
`define FPSC_A_CFG       8'h0c
// ============================================================
// device-side event inputs and factory strap are ports
`endif

// *** src/fpsc_pkg.sv ***
// types shared by both ends of the command link
package fpsc_pkg;
  // device power state
  typedef enum logic [1:0] {fpsc_st_stby, fpsc_st_entry, fpsc_st_pd}
    fpsc_pwr_t;
  // host sequencer state
  typedef enum logic [1:0] {fpsc_h_idle, fpsc_h_low, fpsc_h_done}
    fpsc_hst_t;
endpackage : fpsc_pkg

// *** src/fpsc_if.sv ***
// serial link between host controller and the flash command block
`timescale 1ns/10ps
interface fpsc_if;
  logic       sck;      // serial clock, host driven
  logic       cs_n;     // chip select, active low
  logic [3:0] io_h_o;   // host drive values
  logic [3:0] io_h_oe;  // host drive enables
  logic [3:0] io_d_o;   // device drive values
  logic [3:0] io_d_oe;  // device drive enables
  logic [3:0] io;       // resolved line levels
  always_comb
    for (int i = 0; i < 4; i++)
      io[i] = io_h_oe[i] ? io_h_o[i] : (io_d_oe[i] ? io_d_o[i] : 1'b1);
  modport host (output sck, output cs_n, output io_h_o, output io_h_oe,
                input io);
  modport dev  (input sck, input cs_n, output io_d_o, output io_d_oe,
                input io);
endinterface : fpsc_if

// *** src/fpsc_dev.sv ***
// device end: opcode receiver, power-down, otp mode, security register
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`include "fpsc_defs.svh"
module fpsc_dev
  import fpsc_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // link
  fpsc_if.dev       lnk,
  // mode and status events from the array engine
  input  wire logic quad_mode,       // quad command mode
  input  wire logic factory_lock,    // factory otp lock strap
  input  wire logic erase_done,      // erase finished, pulse
  input  wire logic erase_ok,        // with erase_done: success
  input  wire logic prog_done,       // program finished, pulse
  input  wire logic prog_ok,         // with prog_done: success
  input  wire logic erase_susp,      // erase suspend took effect
  input  wire logic erase_resume,    // erase resumed
  input  wire logic prog_susp,       // program suspend took effect
  input  wire logic prog_resume,     // program resumed
  input  wire logic pmsel_set,       // protection-mode select cmd done
  input  wire logic prog_req,        // program request to otp region
  // outputs
  output logic      deep_pd,         // in deep power-down
  output logic      otp_mode,        // otp region mapped in
  output logic      otp_prog_allow,  // otp program permitted
  output logic [7:0] sec_reg         // security register value
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [2:0]  sck_s;    // sync of sck plus history
    logic [1:0]  cs_s;     // sync of cs_n
    logic        cs_p;     // previous synced cs_n
    logic [3:0]  io_m;     // first sync stage of io
    logic [3:0]  io_s;     // second sync stage of io
    logic [3:0]  bits;     // clocks counted in frame
    logic [7:0]  sh;       // opcode shift
    logic [7:0]  op;       // captured opcode
    logic        op_ok;    // opcode complete, no extra clocks
    logic        rd_on;    // shifting register out
    logic [7:0]  rd_sh;    // output shifter
    logic        write_enable_latch;      // write enable latch
    fpsc_pwr_t   pwr;      // power state
    logic [13:0] dly;      // entry delay counter
    logic        otp;      // otp mode
    logic        lock;     // customer lock
    logic        pmsel;    // protection mode select
    logic        efail, pfail, esus, psus; // volatile flags
    logic        fact;     // captured factory strap
  } fpsc_dst_t;
  fpsc_dst_t s_q, s_d;
  logic      sck_rise, sck_fall, cs_rise, cs_fall;
  logic [7:0] sreg;

  // ==========================================================
  // register composition, bit4 reads zero
  always_comb
  begin
    sreg = 8'h00;
    sreg[`FPSC_B_PMSEL] = s_q.pmsel;
    sreg[`FPSC_B_EFAIL] = s_q.efail;
    sreg[`FPSC_B_PFAIL] = s_q.pfail;
    sreg[`FPSC_B_ESUS]  = s_q.esus;
    sreg[`FPSC_B_PSUS]  = s_q.psus;
    sreg[`FPSC_B_LOCK]  = s_q.lock;
    sreg[`FPSC_B_FACT]  = s_q.fact;
  end

  // edges come only from the second sync stage
  assign sck_rise = s_q.sck_s[1] & ~s_q.sck_s[2];
  assign sck_fall = ~s_q.sck_s[1] & s_q.sck_s[2];
  assign cs_rise  = s_q.cs_s[1] & ~s_q.cs_p;
  assign cs_fall  = ~s_q.cs_s[1] & s_q.cs_p;

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.sck_s = {s_q.sck_s[1:0], lnk.sck};
    s_d.cs_s  = {s_q.cs_s[0], lnk.cs_n};
    s_d.cs_p  = s_q.cs_s[1];
    s_d.io_m  = lnk.io;
    s_d.io_s  = s_q.io_m;
    s_d.fact  = factory_lock;  // strap sampled by clock, not reset
    // frame start clears the opcode receiver
    if (cs_fall)
    begin
      s_d.bits  = 4'h0;
      s_d.op_ok = 1'b0;
      s_d.rd_on = 1'b0;
    end
    // opcode shift on rising serial clock
    if (sck_rise && !s_q.cs_s[1] && !s_q.rd_on)
    begin
      if (quad_mode)
        s_d.sh = {s_q.sh[3:0], s_q.io_s};
      else            // single line: upper lines ignored
        s_d.sh = {s_q.sh[6:0], s_q.io_s[0]};
      s_d.bits = (s_q.bits == 4'hf) ? 4'hf : s_q.bits + 4'h1;
      if ((quad_mode && s_q.bits == 4'h1) ||
          (!quad_mode && s_q.bits == 4'h7))
      begin
        s_d.op    = quad_mode ? {s_q.sh[3:0], s_q.io_s}
                              : {s_q.sh[6:0], s_q.io_s[0]};
        s_d.op_ok = 1'b1;
        // read-security starts shifting at once, any state but pd
        if (s_d.op == `FPSC_OP_READ_SECURITY_CMD && s_q.pwr != fpsc_st_pd)
        begin
          s_d.rd_on = 1'b1;
          s_d.rd_sh = sreg;
        end
      end
      else
        s_d.op_ok = 1'b0;          // extra clock breaks boundary
    end
    // read data shifts out on falling serial clock
    if (sck_fall && s_q.rd_on && !s_q.cs_s[1])
      s_d.rd_sh = quad_mode ? {s_q.rd_sh[3:0], s_q.rd_sh[7:4]}
                            : {s_q.rd_sh[6:0], s_q.rd_sh[7]};
    // commands execute when select rises on an exact boundary
    if (cs_rise)
    begin
      s_d.rd_on = 1'b0;
      if (s_q.op_ok)
      begin
        if (s_q.pwr == fpsc_st_pd)
        begin
          if (s_q.op == `FPSC_OP_RDP)
            s_d.pwr = fpsc_st_stby;
        end
        else
          case (s_q.op)
            `FPSC_OP_WRITE_ENABLE_CMD: s_d.write_enable_latch = 1'b1;
            `FPSC_OP_DP:
            begin
              s_d.pwr = fpsc_st_entry;
              s_d.dly = 14'h0000;
            end
            `FPSC_OP_ENTER_OTP_MODE_CMD: s_d.otp = 1'b1;
            `FPSC_OP_EXIT_OTP_MODE_CMD: s_d.otp = 1'b0;
            `FPSC_OP_WRITE_SECURITY_CMD:
            begin
              if (s_q.write_enable_latch && !s_q.lock)
                s_d.lock = 1'b1;
              s_d.write_enable_latch = 1'b0;
            end
            default: ;
          endcase
      end
    end
    // entry delay before power-down takes hold
    if (s_q.pwr == fpsc_st_entry)
    begin
      s_d.dly = s_q.dly + 14'h0001;
      if (s_q.dly == 14'(`FPSC_TDP_CYC - 1))
        s_d.pwr = fpsc_st_pd;
    end
    // status flags from the array engine; set wins over clear
    if (erase_done)
      s_d.efail = ~erase_ok;
    if (prog_done)
      s_d.pfail = ~prog_ok;
    if (erase_resume)
      s_d.esus = 1'b0;
    if (erase_susp)
      s_d.esus = 1'b1;
    if (prog_resume)
      s_d.psus = 1'b0;
    if (prog_susp)
      s_d.psus = 1'b1;
    if (pmsel_set && s_q.pwr != fpsc_st_pd)
      s_d.pmsel = 1'b1;            // one-way
  end

  // ==========================================================
  // registers; nonvolatile bits modelled as reset-clear storage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.sck_s <= 3'h0;
      s_q.cs_s  <= 2'h3;
      s_q.cs_p  <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs
  assign deep_pd        = (s_q.pwr == fpsc_st_pd);
  assign otp_mode       = s_q.otp;
  assign otp_prog_allow = s_q.otp & ~s_q.lock & prog_req;
  assign sec_reg        = sreg;
  // serial output: io1 in single mode, all four in quad
  assign lnk.io_d_o  = quad_mode ? s_q.rd_sh[7:4]
                                 : {2'b00, s_q.rd_sh[7], 1'b0};
  assign lnk.io_d_oe = !s_q.rd_on ? 4'h0 : (quad_mode ? 4'hf : 4'h2);
endmodule : fpsc_dev

// *** src/fpsc_host.sv ***
// host end: ahb-lite slave registers and a serial command sequencer
`timescale 1ns/10ps
`include "fpsc_defs.svh"
module fpsc_host
  import fpsc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // link
  fpsc_if.host             lnk
);
  // ==========================================================
  // state
  typedef struct packed {
    logic        ap;       // write data phase pending
    logic [7:0]  aa;       // latched address
    logic [31:0] rdat;     // read data register
    fpsc_hst_t   st;       // sequencer
    logic [7:0]  op;       // opcode to send
    logic        rd;       // read one byte back
    logic        quad;     // quad command mode
    logic [4:0]  nclk;     // serial clocks to issue
    logic [4:0]  cnt;      // clocks issued
    logic [2:0]  div;      // half period divider
    logic        sck;
    logic        cs_n;
    logic [15:0] tx;       // outgoing bits
    logic [7:0]  rx;       // incoming byte
    logic [3:0]  io_m, io_s; // io synchroniser
    logic [7:0]  res;      // last read result
  } fpsc_hst_s_t;
  fpsc_hst_s_t s_q, s_d;
  logic       busy;

  assign busy = (s_q.st != fpsc_h_idle);

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.io_m = lnk.io;
    s_d.io_s = s_q.io_m;
    s_d.ap = 1'b0;
    // address phase: writes latch, reads prepare data
    if (hsel && hready && htrans[1])
    begin
      s_d.ap = hwrite;
      s_d.aa = haddr;
      case (haddr)
        `FPSC_A_STAT:  s_d.rdat = {31'h0, busy};
        `FPSC_A_RDATA: s_d.rdat = {24'h0, s_q.res};
        `FPSC_A_CFG:   s_d.rdat = {31'h0, s_q.quad};
        default:       s_d.rdat = 32'h0;
      endcase
    end
    // data phase of a write
    if (s_q.ap)
    begin
      if (s_q.aa == `FPSC_A_CFG)
        s_d.quad = hwdata[0];
      if (s_q.aa == `FPSC_A_CMD && !busy)
      begin
        // byte-exact framing: 8 or 2 clocks per byte
        s_d.op   = hwdata[7:0];
        s_d.rd   = hwdata[8];
        s_d.nclk = s_q.quad ? (hwdata[8] ? 5'd4 : 5'd2)
                            : (hwdata[8] ? 5'd16 : 5'd8);
        s_d.tx   = {hwdata[7:0], 8'h00};
        s_d.cnt  = 5'd0;
        s_d.div  = 3'd0;
        s_d.cs_n = 1'b0;
        s_d.st   = fpsc_h_low;
      end
    end
    // serial engine: sck low then high, data set while low
    case (s_q.st)
      fpsc_h_idle: ;
      fpsc_h_low:
      begin
        s_d.div = s_q.div + 3'd1;
        if (s_q.div == 3'(`FPSC_SCK_HALF - 1))
        begin
          s_d.div = 3'd0;
          s_d.sck = ~s_q.sck;
          if (s_q.sck)
          begin
            // falling edge: advance output, count clock
            s_d.tx  = s_q.quad ? {s_q.tx[11:0], 4'h0}
                               : {s_q.tx[14:0], 1'b0};
            s_d.cnt = s_q.cnt + 5'd1;
            if (s_q.cnt + 5'd1 == s_q.nclk)
              s_d.st = fpsc_h_done;
          end
          else if (s_q.rd && s_q.cnt >= (s_q.nclk >> 1))
            s_d.rx = s_q.quad ? {s_q.rx[3:0], s_q.io_s}
                              : {s_q.rx[6:0], s_q.io_s[1]};
        end
      end
      fpsc_h_done:
      begin
        s_d.div = s_q.div + 3'd1;
        if (s_q.div == 3'(`FPSC_SCK_HALF - 1))
        begin
          s_d.cs_n = 1'b1;          // select ends the frame
          s_d.res  = s_q.rx;
          s_d.st   = fpsc_h_idle;
        end
      end
      default: s_d.st = fpsc_h_idle;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.cs_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs: zero wait states, always okay
  assign hrdata    = s_q.rdat;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign lnk.sck   = s_q.sck;
  assign lnk.cs_n  = s_q.cs_n;
  assign lnk.io_h_o  = s_q.quad ? s_q.tx[15:12] : {3'b000, s_q.tx[15]};
  assign lnk.io_h_oe = (s_q.st == fpsc_h_idle || (s_q.rd && s_q.cnt >=
                        (s_q.nclk >> 1))) ? 4'h0
                       : (s_q.quad ? 4'hf : 4'h1);
endmodule : fpsc_host

// *** test/fpsc_properties.sv ***
// assertions watching the serial link and the device outputs
`timescale 1ns/10ps
module fpsc_properties
(
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // link signals
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic [3:0] io_d_oe,
  // device side
  input wire logic       quad_mode,
  input wire logic       factory_lock,
  input wire logic       erase_done,
  input wire logic       erase_ok,
  input wire logic       prog_susp,
  input wire logic       prog_req,
  input wire logic       deep_pd,
  input wire logic       otp_mode,
  input wire logic       otp_prog_allow,
  input wire logic [7:0] sec_reg
);
  // ============================================================
  // helper counters
  localparam int TDP_MIN = 499; // entry delay, one cycle of sync slack
  logic       sck_q;            // sck one cycle ago
  logic [9:0] edge_q;           // sck rises in this frame
  logic [9:0] idle_q;           // cycles since select rose, saturating
  // count sck rises while selected and idle time after the frame
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_q  <= 1'b0;
      edge_q <= 10'h0;
      idle_q <= 10'h0;
    end
    else
    begin
      sck_q  <= sck;
      edge_q <= cs_n ? 10'h0 : edge_q + {9'h0, sck & ~sck_q};
      idle_q <= !cs_n ? 10'h0 : idle_q + {9'h0, idle_q != 10'h3ff};
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ============================================================
  // sequences and properties
  sequence s_end;
    $rose(cs_n);
  endsequence
  // device output may lag select by the sync stages only
  sequence s_quiet;
    cs_n [*4];
  endsequence
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("serial clock not idle outside frame");
  property p_frame;
    s_end |-> edge_q != 10'h0 &&
      (quad_mode ? edge_q[0] == 1'b0 : edge_q[2:0] == 3'h0);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame not a whole number of bytes");
  property p_quiet;
    s_quiet |-> io_d_oe == 4'h0;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("device drives while deselected");
  property p_lane;
    !quad_mode |-> io_d_oe == 4'h0 || io_d_oe == 4'h2;
  endproperty
  a_lane: assert property (p_lane)
    else $error("device drives a wrong line in single mode");
  property p_pd_delay;
    $rose(deep_pd) |-> idle_q >= TDP_MIN;
  endproperty
  a_pd_delay: assert property (p_pd_delay)
    else $error("power-down entered too early");
  property p_pd_mute;
    deep_pd |-> io_d_oe == 4'h0;
  endproperty
  a_pd_mute: assert property (p_pd_mute)
    else $error("device answers in power-down");
  property p_efail;
    erase_done |=> sec_reg[6] == !$past(erase_ok);
  endproperty
  a_efail: assert property (p_efail)
    else $error("erase fail flag wrong");
  property p_psus;
    prog_susp |=> sec_reg[2];
  endproperty
  a_psus: assert property (p_psus)
    else $error("program suspend flag not set");
  property p_fact;
    $past(hresetn) |-> sec_reg[0] == $past(factory_lock);
  endproperty
  a_fact: assert property (p_fact)
    else $error("factory lock bit wrong");
  property p_rsv;
    sec_reg[4] == 1'b0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bit set");
  property p_lock;
    sec_reg[1] |=> sec_reg[1];
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock flag cleared");
  property p_pmsel;
    sec_reg[7] |=> sec_reg[7];
  endproperty
  a_pmsel: assert property (p_pmsel)
    else $error("protection select cleared");
  property p_otp;
    otp_prog_allow == (otp_mode & ~sec_reg[1] & prog_req);
  endproperty
  a_otp: assert property (p_otp)
    else $error("otp program permit wrong");
endmodule : fpsc_properties

// *** test/fpsc_tb.sv ***
// self-checking bench: host and device ends joined over the link
`timescale 1ns/10ps
`include "fpsc_defs.svh"
module fpsc_tb;
  // ============================================================
  // signals and model state
  logic        hclk, hresetn, hsel, hwrite, hreadyout;
  logic [7:0]  haddr;        // bus address
  logic [1:0]  htrans;       // transfer kind
  logic [2:0]  hsize;        // always a word
  logic [31:0] hwdata;       // write data
  logic [31:0] hrdata;       // read data
  logic        quad_mode;    // device quad mode, follows host cfg
  logic        factory_lock; // factory strap
  logic [6:0]  evv;          // one-hot event pulses
  logic        eok;          // success qualifier for done pulses
  logic        prog_req;     // otp program request
  logic        deep_pd, otp_mode, otp_prog_allow;
  logic [7:0]  sec_reg;      // device security register
  logic [31:0] seed;         // lfsr state
  logic [31:0] r;            // last bus read
  int          fail_count, n_compared, cyc;
  int          m_sec, m_wel, m_otp, m_pd; // model state
  // ============================================================
  // ends of the link and the checker
  fpsc_if fpsc_if_i ();
  fpsc_host fpsc_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .lnk(fpsc_if_i));
  fpsc_dev fpsc_dev_i (.hclk(hclk), .hresetn(hresetn), .lnk(fpsc_if_i),
    .quad_mode(quad_mode), .factory_lock(factory_lock),
    .erase_done(evv[0]), .erase_ok(eok), .prog_done(evv[1]),
    .prog_ok(eok), .erase_susp(evv[2]), .erase_resume(evv[3]),
    .prog_susp(evv[4]), .prog_resume(evv[5]), .pmsel_set(evv[6]),
    .prog_req(prog_req), .deep_pd(deep_pd), .otp_mode(otp_mode),
    .otp_prog_allow(otp_prog_allow), .sec_reg(sec_reg));
  fpsc_properties fpsc_properties_i (.hclk(hclk), .hresetn(hresetn),
    .sck(fpsc_if_i.sck), .cs_n(fpsc_if_i.cs_n),
    .io_d_oe(fpsc_if_i.io_d_oe), .quad_mode(quad_mode),
    .factory_lock(factory_lock), .erase_done(evv[0]), .erase_ok(eok),
    .prog_susp(evv[4]), .prog_req(prog_req), .deep_pd(deep_pd),
    .otp_mode(otp_mode), .otp_prog_allow(otp_prog_allow),
    .sec_reg(sec_reg));
  // ============================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // one single transfer; entered just after a rising edge
  task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // device levels and register against the model
  task outs();
    chk({5'h0, deep_pd, otp_mode, otp_prog_allow}, {5'h0, m_pd[0],
        m_otp[0], m_otp[0] & ~m_sec[1] & prog_req});
    chk(sec_reg, m_sec[7:0]);
  endtask : outs
  // send one opcode, wait for the sequencer, then update the model
  task cmd(input logic [7:0] op, input logic rb);
    ahb(`FPSC_A_CMD, 1'b1, {23'h0, rb, op}, r);
    repeat (2) @(posedge hclk);
    r = 32'h1;
    while (r[0] !== 1'b0)
      ahb(`FPSC_A_STAT, 1'b0, 32'h0, r);
    repeat (8) @(posedge hclk);
    // power-down swallows everything but release
    // a frame with extra clocks after the opcode runs nothing
    if ((m_pd == 0 || op == `FPSC_OP_RDP) &&
        (!rb || op == `FPSC_OP_READ_SECURITY_CMD))
      case (op)
        `FPSC_OP_WRITE_ENABLE_CMD: m_wel = 1;
        `FPSC_OP_RDP:  m_pd = 0;
        `FPSC_OP_ENTER_OTP_MODE_CMD: m_otp = 1;
        `FPSC_OP_EXIT_OTP_MODE_CMD: m_otp = 0;
        `FPSC_OP_WRITE_SECURITY_CMD:
        begin
          m_sec = m_sec | (m_wel << 1);
          m_wel = 0;
        end
        default: m_wel = m_wel;
      endcase
    outs();
  endtask : cmd
  // read the security byte over the link; released line reads ones
  task rdsec();
    cmd(`FPSC_OP_READ_SECURITY_CMD, 1'b1);
    ahb(`FPSC_A_RDATA, 1'b0, 32'h0, r);
    chk(r[7:0], m_pd ? 8'hff : m_sec[7:0]);
  endtask : rdsec
  // one event pulse to the device
  task ev(input int k, input logic ok);
    int bp [7] = '{6, 5, 3, 3, 2, 2, 7};
    evv <= 7'h01 << k;
    eok <= ok;
    @(posedge hclk);
    evv <= 7'h00;
    @(posedge hclk);
    m_sec[bp[k]] = (k < 2) ? !ok : (k != 3 && k != 5);
    outs();
  endtask : ev
  // ============================================================
  // clock and timeout
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      test_done();
    end
  end
  // ============================================================
  // main sequence
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    {quad_mode, factory_lock, evv, eok, prog_req} = '0;
    {fail_count, n_compared, cyc, m_sec, m_wel, m_otp, m_pd} = '0;
    seed = 32'h800d;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    outs();
    rdsec();
    $display("test reset done");
    for (int i = 0; i < 28; i++)
    begin
      seed = lfsr(seed);
      ev((i < 14) ? i % 7 : seed[2:0] % 7,
         (i < 14) ? i >= 7 : seed[3]);
      if (i % 5 == 0)
        rdsec();
    end
    $display("test flags done");
    prog_req <= 1'b1;
    cmd(`FPSC_OP_ENTER_OTP_MODE_CMD, 1'b0);
    cmd(`FPSC_OP_WRITE_SECURITY_CMD, 1'b0);
    cmd(`FPSC_OP_WRITE_ENABLE_CMD, 1'b0);
    cmd(`FPSC_OP_WRITE_SECURITY_CMD, 1'b0);
    cmd(`FPSC_OP_WRITE_ENABLE_CMD, 1'b0);
    cmd(`FPSC_OP_WRITE_SECURITY_CMD, 1'b0);
    cmd(`FPSC_OP_EXIT_OTP_MODE_CMD, 1'b0);
    $display("test otp done");
    ahb(`FPSC_A_CFG, 1'b1, 32'h1, r);
    quad_mode <= 1'b1;
    ahb(`FPSC_A_CFG, 1'b0, 32'h0, r);
    chk(r[7:0], 8'h01);
    ahb(8'h10, 1'b0, 32'h0, r);
    chk(r[7:0], 8'h00);
    rdsec();
    cmd(`FPSC_OP_ENTER_OTP_MODE_CMD, 1'b0);
    cmd(`FPSC_OP_EXIT_OTP_MODE_CMD, 1'b0);
    ahb(`FPSC_A_CFG, 1'b1, 32'h0, r);
    quad_mode <= 1'b0;
    $display("test quad done");
    cmd(`FPSC_OP_DP, 1'b1);
    repeat (520) @(posedge hclk);
    outs();
    cmd(`FPSC_OP_DP, 1'b0);
    repeat (520) @(posedge hclk);
    m_pd = 1;
    outs();
    cmd(`FPSC_OP_ENTER_OTP_MODE_CMD, 1'b0);
    rdsec();
    cmd(`FPSC_OP_RDP, 1'b0);
    cmd(`FPSC_OP_DP, 1'b0);
    repeat (520) @(posedge hclk);
    factory_lock <= 1'b1;
    hresetn <= 1'b0;
    {m_sec, m_wel, m_otp, m_pd} = '0;
    repeat (3) @(posedge hclk);
    outs();
    hresetn <= 1'b1;
    m_sec = 1;
    repeat (2) @(posedge hclk);
    outs();
    rdsec();
    $display("test power-down done");
    test_done();
  end
endmodule : fpsc_tb
